/* dv/lle_par_model.sv */
/*
 Parameter store seen by the engine in parameter addressing mode.
 Assumes par_rdata is sampled while par_valid is high.
*/
`timescale 1ns/10ps
module lle_par_model (
   input wire logic clk,
   input wire logic par_valid,
   input wire logic [15:0] par_addr,
   output logic [15:0] par_rdata
);
   logic [15:0] junk_q = 16'h5a5a;

   // Churn when idle, so a stale sample never looks right
   always @(posedge clk) begin
      junk_q <= junk_q + 16'h3c5b;
   end

   assign par_rdata = par_valid ? ~par_addr : junk_q;
endmodule

/* dv/tb_lle_engine.sv */
/*
 Self-checking bench of the ladder engine: bus access, refusals, two scans.
 Assumes the engine and the parameter store model of this folder.
*/
`timescale 1ns/10ps
module tb_lle_engine;
   import lle_pkg::*;
   logic clk, nrst, ce, run_en, dmode, req_valid, req_ready, rsp_valid, scan_done, par_valid;
   logic [7:0] pc;
   logic [15:0] x_in, y_out, par_addr, par_rdata, par_wdata, w0, w1, w2, exp_y;
   logic par_write;
   logic [16:0] par_exp;
   lle_req_s req;
   lle_rsp_s rsp;
   lle_instr_s prog [256];
   logic [24:0] exp_q [$];
   logic [24:0] e;
   int bad_count, checks, cyc, seed, n;
   lle_op_e ops [43] = '{OP_LOAD, OP_AND, OP_OUT, OP_LOADN, OP_ANDN, OP_OUT, OP_LOAD, OP_OR, OP_OUT,
      OP_LOAD, OP_ORN, OP_OUT, OP_LOAD, OP_LOAD, OP_BAND, OP_OUT, OP_LOAD, OP_LOAD, OP_BOR, OP_OUT,
      OP_LOAD, OP_PUSH, OP_CPL, OP_OUT, OP_PEEK, OP_OUT, OP_POP, OP_AND, OP_OUT,
      OP_LOADN, OP_OR, OP_RST, OP_RST, OP_LDR, OP_ANR, OP_OUT, OP_LOADN, OP_MCO, OP_LOAD, OP_OUT, OP_MCC,
      OP_PLR, OP_END};
   logic [15:0] adr [43] = '{16'h0400, 16'h0401, 16'h0500, 16'h0400, 16'h0401, 16'h0501,
      16'h0400, 16'h0401, 16'h0502, 16'h0400, 16'h0401, 16'h0503, 16'h0400, 16'h0401, 16'h0, 16'h0504,
      16'h0400, 16'h0401, 16'h0, 16'h0505, 16'h0400, 16'h0, 16'h0, 16'h0506, 16'h0, 16'h0507,
      16'h0, 16'h0401, 16'h0508, 16'h0400, 16'h0400, 16'h0509, 16'h1005, 16'h0400, 16'h0401, 16'h050a,
      16'h0400, 16'h0, 16'h0401, 16'h050b, 16'h0, 16'h050c, 16'h0};

   lle_engine dut (.clk(clk), .nrst(nrst), .ce(ce), .run_en(run_en), .device_addressing_mode(dmode),
      .pc(pc), .instr(prog[pc]), .scan_done(scan_done), .x_in(x_in), .y_out(y_out),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .par_valid(par_valid), .par_write(par_write), .par_addr(par_addr), .par_wdata(par_wdata),
      .par_rdata(par_rdata));
   lle_par_model par (.clk(clk), .par_valid(par_valid), .par_addr(par_addr), .par_rdata(par_rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Held from a falling edge until a rising edge sees ready
   task automatic beat(input lle_req_s r);
      @(negedge clk);
      req = r;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) bad_count++;
      @(posedge clk);
   endtask

   // Top bit of the note says whether the data field matters
   task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [4:0] c, input logic [15:0] w,
         input logic [24:0] x);
      exp_q.push_back(x);
      beat('{func: f, addr: a, count: c, wdata: w});
      @(negedge clk) req_valid = 1'b0;
   endtask

   // Oldest note against each answer
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 25'h1ffffff;
         if (e[24]) check("rsp", rsp, e[23:0]);
         else check("rsp_exc", {rsp.exc, 16'h0}, {e[23:16], 16'h0});
      end
      if (par_valid === 1'b1) check("par_req", {par_write, par_wdata}, par_exp);
   end

   // Hang guard, far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   initial begin
      seed = 11;
      {nrst, run_en, req_valid, x_in, req} = '0;
      {ce, dmode} = 2'b11;
      for (int i = 0; i < 256; i++) prog[i] = '{op: i < 43 ? ops[i] : OP_END, addr: i < 43 ? adr[i] : 16'h0};
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      x_in = 16'($random(seed));
      w0 = 16'($random(seed));
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      op(FC_RD_INPUT, X_BASE, 5'h10, 16'h0, {1'b1, EXC_NONE, x_in});
      op(FC_WR_COIL, M_LAST, 5'h1, COIL_ON, {1'b0, EXC_NONE, 16'h0});
      op(FC_RD_COIL, M_LAST - 16'h1, 5'h2, 16'h0, {1'b1, EXC_NONE, 16'h0002});
      op(FC_WR_COILS, Y_BASE, 5'h10, w0, {1'b0, EXC_NONE, 16'h0});
      check("y_out", y_out, w0);
      op(FC_RD_COIL, Y_BASE, 5'h10, 16'h0, {1'b1, EXC_NONE, w0});
      op(FC_WR_WORD, D_BASE, 5'h1, w1, {1'b0, EXC_NONE, 16'h0});
      exp_q.push_back({1'b0, EXC_NONE, 16'h0});
      beat('{func: FC_WR_WORDS, addr: D_BASE + 16'h1, count: 5'h2, wdata: w2});
      beat('{func: FC_WR_WORDS, addr: D_BASE + 16'h1, count: 5'h2, wdata: ~w2});
      @(negedge clk) req_valid = 1'b0;
      op(FC_RD_WORD, D_BASE, 5'h1, 16'h0, {1'b1, EXC_NONE, w1});
      op(FC_RD_WORD, D_BASE + 16'h2, 5'h1, 16'h0, {1'b1, EXC_NONE, ~w2});
      // refusals: unknown code, word count, bit device read as word
      op(8'h07, D_BASE, 5'h1, 16'h0, {1'b1, EXC_FUNC, 16'h0});
      op(FC_RD_WORD, D_BASE, 5'h2, 16'h0, {1'b1, EXC_ADDR, 16'h0});
      op(FC_RD_WORD, X_BASE, 5'h1, 16'h0, {1'b1, EXC_ADDR, 16'h0});
      op(FC_WR_COIL, Y_BASE + 16'h9, 5'h1, COIL_ON, {1'b0, EXC_NONE, 16'h0});
      op(FC_WR_WORD, D_BASE + 16'h5, 5'h1, w1, {1'b0, EXC_NONE, 16'h0});
      // Two scans: edge and pulse bits must fall back on the second one
      exp_y = {w0[15:13], x_in[1], x_in[1] & ~x_in[0], x_in[0] & x_in[1], 1'b0, x_in[0] & x_in[1],
         x_in[0], ~x_in[0], x_in[0] | x_in[1], x_in[0] & x_in[1], x_in[0] | ~x_in[1], x_in[0] | x_in[1],
         ~x_in[0] & ~x_in[1], x_in[0] & x_in[1]};
      for (int s = 0; s < 2; s++) begin
         @(negedge clk) run_en = 1'b1;
         n = 0;
         while (scan_done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
         end
         run_en = 1'b0;
         if (n == 500) bad_count++;
         check("y_scan", y_out, exp_y);
         check("pulse_y", y_out[12], s == 0 && x_in[1]);
         check("edge_y", y_out[10], s == 0 && x_in[0] && x_in[1]);
         check("sect_y", y_out[11], x_in[1] && !x_in[0]);
         exp_y = exp_y & 16'hebff;
      end
      op(FC_RD_INPUT, Y_BASE, 5'h10, 16'h0, {1'b1, EXC_NONE, exp_y});
      op(FC_RD_WORD, D_BASE + 16'h5, 5'h1, 16'h0, {1'b1, EXC_NONE, 16'h0});
      // parameter addressing, a read then a write
      @(negedge clk) dmode = 1'b0;
      par_exp = 17'h0;
      op(FC_RD_WORD, X_BASE, 5'h1, 16'h0, {1'b1, EXC_NONE, ~X_BASE});
      @(negedge clk) par_exp = {1'b1, w2};
      op(FC_WR_WORD, 16'h0102, 5'h1, w2, {1'b0, EXC_NONE, 16'h0});
      repeat (3) @(negedge clk);
      check("pending", 24'(exp_q.size()), 24'h0);
      test_done();
   end
endmodule

/* rtl/lle_engine.sv */
/*
 Ladder-logic engine with device memory and serial-master access port.
 Assumes a program store answering pc in the same cycle, and a parameter
 store answering par_addr in the same cycle as par_valid.
*/
`timescale 1ns/10ps
module lle_engine import lle_pkg::*; #(
   parameter int PROG_DEPTH = 256,
   parameter int STACK_DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run_en,
   input wire logic device_addressing_mode,
   output logic [$clog2(PROG_DEPTH)-1:0] pc,
   input wire lle_instr_s instr,
   output logic scan_done,
   input wire logic [N_X-1:0] x_in,
   output logic [N_Y-1:0] y_out,
   input wire logic req_valid,
   input wire lle_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output lle_rsp_s rsp,
   output logic par_valid,
   output logic par_write,
   output logic [15:0] par_addr,
   output logic [15:0] par_wdata,
   input wire logic [15:0] par_rdata
);
   localparam int PW = $clog2(PROG_DEPTH);
   localparam int SW = $clog2(STACK_DEPTH);

   logic [1:0] sync_q;
   logic rst_n;
   logic [PW-1:0] pc_q, pc_d;
   logic acc_q, acc_d, scan_done_q, scan_done_d;
   logic [STACK_DEPTH-1:0] bstk_q, bstk_d, rstk_q, rstk_d;
   logic [SW-1:0] bsp_q, bsp_d, rptr_q, rptr_d;
   logic [N_SEC-1:0] mact_q, mact_d, mcond_q, mcond_d;
   logic [PROG_DEPTH-1:0] edge_q, edge_d;
   logic [N_Y-1:0] y_q, y_d;
   logic [N_M-1:0] m_q, m_d;
   logic [N_T-1:0] tb_q, tb_d;
   logic [N_C-1:0] cb_q, cb_d;
   logic [N_T-1:0][15:0] tw_q, tw_d;
   logic [N_C-1:0][15:0] cw_q, cw_d;
   logic [N_D-1:0][15:0] dw_q, dw_d;
   lle_state_e st_q, st_d;
   logic [15:0] bur_addr_q, bur_addr_d;
   logic [4:0] bur_left_q, bur_left_d;
   logic rsp_valid_q, rsp_valid_d, par_valid_q, par_valid_d, par_write_q, par_write_d;
   lle_rsp_s rsp_q, rsp_d;
   logic [15:0] par_addr_q, par_addr_d, par_wdata_q, par_wdata_d;
   logic step, take, gate, cur, prev, rise, fall, btop, rtop;
   lle_loc_s loc, l0, ll, lw;
   logic [4:0] cnt;

   // Reset released through two flops so the release is clean
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_q <= 2'b00;
      end else begin
         sync_q <= {sync_q[0], 1'b1};
      end
   end
   assign rst_n = sync_q[1];

   // Contact and word readers over the live memory
   function automatic logic bit_at(input lle_loc_s l);
      unique case (l.cls)
         CL_X: bit_at = x_in[l.idx[3:0]];
         CL_Y: bit_at = y_q[l.idx[3:0]];
         CL_T: bit_at = tb_q[l.idx[3:0]];
         CL_M: bit_at = m_q[l.idx];
         CL_C: bit_at = cb_q[l.idx[2:0]];
         default: bit_at = 1'b0;
      endcase
   endfunction
   function automatic logic [15:0] word_at(input lle_loc_s l);
      unique case (l.cls)
         CL_T: word_at = tw_q[l.idx[3:0]];
         CL_C: word_at = cw_q[l.idx[2:0]];
         CL_D: word_at = dw_q[l.idx[4:0]];
         default: word_at = 16'h0000;
      endcase
   endfunction

   // The bus is served at the scan boundary or while run_en is low, so an unbroken scan sees one memory image
   assign req_ready = (st_q == ST_BURST) ||
                      (st_q == ST_RUN && !par_valid_q && (!run_en || instr.op == OP_END));
   assign take = ce && req_valid && req_ready;
   assign step = ce && run_en && st_q == ST_RUN;
   assign loc = lle_locate(instr.addr);
   assign cur = bit_at(loc);
   assign prev = edge_q[pc_q];
   assign rise = cur && !prev;
   assign fall = !cur && prev;
   assign btop = bstk_q[bsp_q - 1'b1];
   assign rtop = rstk_q[rptr_q - 1'b1];
   assign gate = &(mcond_q | ~mact_q);
   assign cnt = (req.count == 5'd0) ? 5'd1 : req.count;
   assign l0 = lle_locate(req.addr);
   assign ll = lle_locate(16'(req.addr + 16'(cnt) - 16'h0001));

   // Next state of engine, device memory and bus port
   always_comb begin
      logic cw, cv, clr, rd_ok, bit_ok, word_ok;
      logic [MAX_CNT-1:0] bw_en, bw_v;
      logic ww;
      logic [15:0] wa, wv;
      lle_loc_s lb;
      cw = 1'b0; cv = 1'b0; clr = 1'b0; rd_ok = 1'b0;
      bw_en = '0; bw_v = '0; ww = 1'b0; wa = req.addr; wv = req.wdata;
      lb = l0;
      pc_d = pc_q; acc_d = acc_q; scan_done_d = 1'b0;
      bstk_d = bstk_q; bsp_d = bsp_q; rstk_d = rstk_q; rptr_d = rptr_q;
      mact_d = mact_q; mcond_d = mcond_q; edge_d = edge_q;
      y_d = y_q; m_d = m_q; tb_d = tb_q; cb_d = cb_q; tw_d = tw_q; cw_d = cw_q; dw_d = dw_q;
      st_d = st_q; bur_addr_d = bur_addr_q; bur_left_d = bur_left_q;
      rsp_valid_d = 1'b0; rsp_d = rsp_q;
      par_valid_d = 1'b0; par_write_d = par_write_q; par_addr_d = par_addr_q; par_wdata_d = par_wdata_q;
      bit_ok = l0.cls == ll.cls && l0.cls inside {CL_Y, CL_M, CL_T, CL_C};
      word_ok = l0.cls == ll.cls && l0.cls inside {CL_T, CL_C, CL_D};
      if (step) begin
         pc_d = pc_q + 1'b1;
         unique case (instr.op)
            OP_LOAD: begin bstk_d[bsp_q] = acc_q; bsp_d = bsp_q + 1'b1; acc_d = cur; end
            OP_LOADN: begin bstk_d[bsp_q] = acc_q; bsp_d = bsp_q + 1'b1; acc_d = !cur; end
            OP_LDR, OP_LDFE: begin
               bstk_d[bsp_q] = acc_q;
               bsp_d = bsp_q + 1'b1;
               acc_d = (instr.op == OP_LDR) ? rise : fall;
               edge_d[pc_q] = cur;
            end
            OP_AND: acc_d = acc_q && cur;
            OP_ANDN: acc_d = acc_q && !cur;
            OP_OR: acc_d = acc_q || cur;
            OP_ORN: acc_d = acc_q || !cur;
            OP_ANR, OP_ANFE, OP_ORR, OP_ORFE: begin
               edge_d[pc_q] = cur;
               unique case (instr.op)
                  OP_ANR: acc_d = acc_q && rise;
                  OP_ANFE: acc_d = acc_q && fall;
                  OP_ORR: acc_d = acc_q || rise;
                  default: acc_d = acc_q || fall;
               endcase
            end
            OP_BAND: begin acc_d = acc_q && btop; bsp_d = bsp_q - 1'b1; end
            OP_BOR: begin acc_d = acc_q || btop; bsp_d = bsp_q - 1'b1; end
            OP_PUSH: begin rstk_d[rptr_q] = acc_q; rptr_d = rptr_q + 1'b1; end
            OP_PEEK: acc_d = rtop;
            OP_POP: begin acc_d = rtop; rptr_d = rptr_q - 1'b1; end
            OP_CPL: acc_d = !acc_q;
            // coil drive, OUT forced off in a closed section, SET and RST held
            OP_OUT: begin cw = 1'b1; cv = acc_q && gate; end
            OP_SET: begin cw = acc_q && gate; cv = 1'b1; end
            OP_RST: clr = acc_q && gate;
            OP_MCO: begin mact_d[instr.addr[2:0]] = 1'b1; mcond_d[instr.addr[2:0]] = acc_q; end
            OP_MCC: begin
               for (int k = 0; k < N_SEC; k++) begin
                  if (k >= int'(instr.addr[2:0])) mact_d[k] = 1'b0;
               end
            end
            OP_PLR, OP_PLFE: begin
               edge_d[pc_q] = acc_q;
               cw = gate;
               cv = (instr.op == OP_PLR) ? (acc_q && !prev) : (!acc_q && prev);
            end
            OP_END: begin pc_d = '0; scan_done_d = 1'b1; end
            default: ;
         endcase
      end
      if (cw || clr) begin
         unique case (loc.cls)
            CL_Y: y_d[loc.idx[3:0]] = cv;
            CL_M: m_d[loc.idx] = cv;
            CL_T: begin tb_d[loc.idx[3:0]] = 1'b0; tw_d[loc.idx[3:0]] = 16'h0000; end
            CL_C: begin cb_d[loc.idx[2:0]] = 1'b0; cw_d[loc.idx[2:0]] = 16'h0000; end
            CL_D: dw_d[loc.idx[4:0]] = 16'h0000;
            default: ;
         endcase
      end
      // Parameter answer returns one cycle after the forwarded access
      if (par_valid_q) begin
         rsp_valid_d = 1'b1;
         rsp_d.exc = EXC_NONE;
         rsp_d.data = par_rdata;
      end
      if (take) begin
         unique case (st_q)
            ST_RUN: begin
               rsp_valid_d = 1'b1;
               rsp_d.exc = EXC_NONE;
               rsp_d.data = 16'h0000;
               if (!device_addressing_mode) begin
                  rsp_valid_d = 1'b0;
                  par_valid_d = 1'b1;
                  par_addr_d = req.addr;
                  par_wdata_d = req.wdata;
                  par_write_d = req.func inside {FC_WR_COIL, FC_WR_WORD, FC_WR_COILS, FC_WR_WORDS};
               end else begin
                  unique case (req.func)
                     FC_RD_COIL, FC_RD_INPUT: begin
                        rd_ok = bit_ok || (req.func == FC_RD_INPUT && l0.cls == CL_X && ll.cls == CL_X);
                        for (int i = 0; i < MAX_CNT; i++) begin
                           if (i < int'(cnt)) begin
                              rsp_d.data[i] = bit_at(lle_locate(16'(req.addr + 16'(i))));
                           end
                        end
                     end
                     FC_RD_WORD: begin rd_ok = word_ok && cnt == 5'd1; rsp_d.data = word_at(l0); end
                     FC_WR_COIL: begin
                        rd_ok = bit_ok && cnt == 5'd1;
                        bw_en[0] = rd_ok;
                        bw_v[0] = req.wdata == COIL_ON;
                     end
                     FC_WR_WORD: begin rd_ok = word_ok && cnt == 5'd1; ww = rd_ok; end
                     FC_WR_COILS: begin
                        rd_ok = bit_ok && cnt <= 5'(MAX_CNT);
                        for (int i = 0; i < MAX_CNT; i++) begin
                           bw_en[i] = rd_ok && i < int'(cnt);
                        end
                        bw_v = req.wdata;
                     end
                     // first word now, the rest as data beats
                     FC_WR_WORDS: begin
                        rd_ok = word_ok;
                        ww = rd_ok;
                        if (rd_ok && cnt > 5'd1) begin
                           st_d = ST_BURST;
                           rsp_valid_d = 1'b0;
                           bur_addr_d = 16'(req.addr + 16'h0001);
                           bur_left_d = 5'(cnt - 5'd1);
                        end
                     end
                     default: rsp_d.exc = EXC_FUNC;
                  endcase
                  if (req.func inside {FC_RD_COIL, FC_RD_INPUT, FC_RD_WORD, FC_WR_COIL,
                                       FC_WR_WORD, FC_WR_COILS, FC_WR_WORDS} && !rd_ok) begin
                     rsp_d.exc = EXC_ADDR;
                     rsp_d.data = 16'h0000;
                  end
               end
            end
            ST_BURST: begin
               ww = 1'b1;
               wa = bur_addr_q;
               bur_addr_d = 16'(bur_addr_q + 16'h0001);
               bur_left_d = 5'(bur_left_q - 5'd1);
               if (bur_left_q == 5'd1) begin
                  st_d = ST_RUN;
                  rsp_valid_d = 1'b1;
                  rsp_d.exc = EXC_NONE;
                  rsp_d.data = 16'h0000;
               end
            end
            default: st_d = ST_RUN;
         endcase
      end
      // Bus writes land after engine writes, so the master wins a tie
      for (int i = 0; i < MAX_CNT; i++) begin
         if (bw_en[i]) begin
            lb = lle_locate(16'(req.addr + 16'(i)));
            unique case (lb.cls)
               CL_Y: y_d[lb.idx[3:0]] = bw_v[i];
               CL_M: m_d[lb.idx] = bw_v[i];
               CL_T: tb_d[lb.idx[3:0]] = bw_v[i];
               CL_C: cb_d[lb.idx[2:0]] = bw_v[i];
               default: ;
            endcase
         end
      end
      lw = lle_locate(wa);
      if (ww) begin
         unique case (lw.cls)
            CL_T: tw_d[lw.idx[3:0]] = wv;
            CL_C: cw_d[lw.idx[2:0]] = wv;
            CL_D: dw_d[lw.idx[4:0]] = wv;
            default: ;
         endcase
      end
   end

   // All state but the reset synchronizer frozen while ce is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= '0; acc_q <= 1'b0; scan_done_q <= 1'b0;
         bstk_q <= '0; bsp_q <= '0; rstk_q <= '0; rptr_q <= '0;
         mact_q <= '0; mcond_q <= '0; edge_q <= '0;
         y_q <= '0; m_q <= '0; tb_q <= '0; cb_q <= '0; tw_q <= '0; cw_q <= '0; dw_q <= '0;
         st_q <= ST_RUN; bur_addr_q <= 16'h0000; bur_left_q <= 5'd0;
         rsp_valid_q <= 1'b0; rsp_q <= '0;
         par_valid_q <= 1'b0; par_write_q <= 1'b0; par_addr_q <= 16'h0000; par_wdata_q <= 16'h0000;
      end else if (ce) begin
         pc_q <= pc_d; acc_q <= acc_d; scan_done_q <= scan_done_d;
         bstk_q <= bstk_d; bsp_q <= bsp_d; rstk_q <= rstk_d; rptr_q <= rptr_d;
         mact_q <= mact_d; mcond_q <= mcond_d; edge_q <= edge_d;
         y_q <= y_d; m_q <= m_d; tb_q <= tb_d; cb_q <= cb_d; tw_q <= tw_d; cw_q <= cw_d; dw_q <= dw_d;
         st_q <= st_d; bur_addr_q <= bur_addr_d; bur_left_q <= bur_left_d;
         rsp_valid_q <= rsp_valid_d; rsp_q <= rsp_d;
         par_valid_q <= par_valid_d; par_write_q <= par_write_d; par_addr_q <= par_addr_d;
         par_wdata_q <= par_wdata_d;
      end
   end

   assign pc = pc_q;
   assign scan_done = scan_done_q;
   assign y_out = y_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp = rsp_q;
   assign par_valid = par_valid_q;
   assign par_write = par_write_q;
   assign par_addr = par_addr_q;
   assign par_wdata = par_wdata_q;

   // Checks tied to the engine and bus behaviour
   a_load_contact: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_LOAD |=> acc_q == $past(cur) && bsp_q == $past(bsp_q) + 1'b1)
      else $error("load did not take contact");
   a_invert_acc: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_CPL |=> acc_q != $past(acc_q)) else $error("complement failed");
   a_push_ptr: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_PUSH |=> rptr_q == $past(rptr_q) + 1'b1) else $error("push pointer wrong");
   a_peek_hold: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_PEEK |=> rptr_q == $past(rptr_q) && acc_q == $past(rtop))
      else $error("peek moved pointer");
   a_pop_ptr: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_POP |=> rptr_q == $past(rptr_q) - 1'b1 && acc_q == $past(rtop))
      else $error("pop wrong");
   a_scan_end: assert property (@(posedge clk) disable iff (!rst_n)
      step && instr.op == OP_END |=> pc_q == '0 && scan_done_q) else $error("scan did not restart");
   a_param_fwd: assert property (@(posedge clk) disable iff (!rst_n)
      take && st_q == ST_RUN && !device_addressing_mode |=> par_valid_q && !rsp_valid_q ##1 rsp_valid_q)
      else $error("parameter access not forwarded");
   a_input_map: assert property (@(posedge clk) disable iff (!rst_n)
      take && st_q == ST_RUN && device_addressing_mode && req.func == FC_RD_INPUT && req.addr == X_BASE
      |=> rsp_valid_q && rsp_q.exc == EXC_NONE && rsp_q.data[0] == $past(x_in[0]))
      else $error("input bit not mapped");
   a_burst_stall: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ST_BURST && ce |=> pc_q == $past(pc_q)) else $error("engine ran during burst");
endmodule

/* rtl/lle_pkg.sv */
/*
 Shared constants and types of the ladder engine: device address map,
 function codes, opcodes and carriers. Assumes nothing of its users.
*/
package lle_pkg;
   localparam logic [15:0] X_BASE = 16'h0400;
   localparam logic [15:0] X_LAST = 16'h040f;
   localparam logic [15:0] Y_BASE = 16'h0500;
   localparam logic [15:0] Y_LAST = 16'h050f;
   localparam logic [15:0] T_BASE = 16'h0600;
   localparam logic [15:0] T_LAST = 16'h060f;
   localparam logic [15:0] M_BASE = 16'h0800;
   localparam logic [15:0] M_LAST = 16'h089f;
   localparam logic [15:0] C_BASE = 16'h0e00;
   localparam logic [15:0] C_LAST = 16'h0e07;
   localparam logic [15:0] D_BASE = 16'h1000;
   localparam logic [15:0] D_LAST = 16'h101d;
   localparam int N_X = 16;
   localparam int N_Y = 16;
   localparam int N_T = 16;
   localparam int N_M = 160;
   localparam int N_C = 8;
   localparam int N_D = 30;
   localparam int N_SEC = 8;
   localparam int MAX_CNT = 16;
   localparam logic [7:0] FC_RD_COIL = 8'h01;
   localparam logic [7:0] FC_RD_INPUT = 8'h02;
   localparam logic [7:0] FC_RD_WORD = 8'h03;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_WORD = 8'h06;
   localparam logic [7:0] FC_WR_COILS = 8'h0f;
   localparam logic [7:0] FC_WR_WORDS = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [15:0] COIL_ON = 16'hff00;
   typedef enum logic [4:0] {
      OP_NOP, OP_LOAD, OP_LOADN, OP_AND, OP_ANDN, OP_OR, OP_ORN, OP_BAND,
      OP_BOR, OP_PUSH, OP_PEEK, OP_POP, OP_CPL, OP_OUT, OP_SET, OP_RST,
      OP_MCO, OP_MCC, OP_LDR, OP_LDFE, OP_ANR, OP_ANFE, OP_ORR, OP_ORFE,
      OP_PLR, OP_PLFE, OP_END
   } lle_op_e;
   typedef enum logic [2:0] {CL_NONE, CL_X, CL_Y, CL_T, CL_M, CL_C, CL_D} lle_cls_e;
   typedef enum logic [1:0] {ST_RUN = 2'b01, ST_BURST = 2'b10} lle_state_e;
   typedef struct packed {lle_op_e op; logic [15:0] addr;} lle_instr_s;
   typedef struct packed {logic [7:0] func; logic [15:0] addr; logic [4:0] count; logic [15:0] wdata;} lle_req_s;
   typedef struct packed {logic [7:0] exc; logic [15:0] data;} lle_rsp_s;
   typedef struct packed {lle_cls_e cls; logic [7:0] idx;} lle_loc_s;

   // Operands share the bus address map, so one decoder serves both
   function automatic lle_loc_s lle_locate(input logic [15:0] a);
      lle_loc_s l;
      l.cls = CL_NONE;
      l.idx = 8'h00;
      if (a >= X_BASE && a <= X_LAST) begin l.cls = CL_X; l.idx = 8'(a - X_BASE); end
      else if (a >= Y_BASE && a <= Y_LAST) begin l.cls = CL_Y; l.idx = 8'(a - Y_BASE); end
      else if (a >= T_BASE && a <= T_LAST) begin l.cls = CL_T; l.idx = 8'(a - T_BASE); end
      else if (a >= M_BASE && a <= M_LAST) begin l.cls = CL_M; l.idx = 8'(a - M_BASE); end
      else if (a >= C_BASE && a <= C_LAST) begin l.cls = CL_C; l.idx = 8'(a - C_BASE); end
      else if (a >= D_BASE && a <= D_LAST) begin l.cls = CL_D; l.idx = 8'(a - D_BASE); end
      return l;
   endfunction
endpackage
